// [cmc_pkg.sv]
`default_nettype none

package cmc_pkg;

    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register addresses
    localparam logic [7:0] CTRL_ADDR = 8'hF8;
    localparam logic [7:0] MODE_ADDR = 8'h9D;

    // Control register field positions
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OUT_BIT = 6;
    localparam int CTRL_RISE_BIT = 5;
    localparam int CTRL_FALL_BIT = 4;
    localparam int CTRL_HYP_LSB = 2;
    localparam int CTRL_HYN_LSB = 0;
    localparam int HYST_W = 2;

    // Mode register field positions
    localparam int MODE_SEL_LSB = 0;
    localparam int MODE_W = 2;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h02;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Synchroniser depth for the latched output
    localparam int SYNC_STAGES = 2;

    // Hysteresis encodings, same for both sides
    typedef enum logic [1:0] {
        CMC_HYST_OFF = 2'h0,
        CMC_HYST_5MV = 2'h1,
        CMC_HYST_10MV = 2'h2,
        CMC_HYST_20MV = 2'h3
    } cmc_hyst_e;

    // Response time modes, fastest to slowest
    typedef enum logic [1:0] {
        CMC_MODE_0 = 2'h0,
        CMC_MODE_1 = 2'h1,
        CMC_MODE_2 = 2'h2,
        CMC_MODE_3 = 2'h3
    } cmc_mode_e;

    // Settings that travel to the analog core together
    typedef struct packed {
        logic power;
        cmc_hyst_e hyst_positive_sel;
        cmc_hyst_e hyst_negative_sel;
        cmc_mode_e response_mode_sel;
    } cmc_core_ctrl_s;

endpackage : cmc_pkg

`default_nettype wire

// [cmc_sync.sv]
`default_nettype none

module cmc_sync #(
    parameter int STAGES = 2
) (
    input wire logic mclk_i,    // System clock
    input wire logic reset_i,   // Synchronous reset, active high
    input wire logic async_i,   // Level from another timing domain
    output logic sync_o         // Level retimed to mclk_i
);
    logic [STAGES-1:0] stage;
    logic [STAGES-1:0] next_stage;

    // The first stage may go metastable, so only the next stage reads it
    always_comb begin
        next_stage = {stage[STAGES-2:0], async_i};
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            stage <= '0;
        end else begin
            stage <= next_stage;
        end
    end

    assign sync_o = stage[STAGES-1];

endmodule : cmc_sync

`default_nettype wire

// [cmc_comparator_ctrl.sv]
// Operation
// - Offer a clock-registered output and a raw unclocked output for port routing.
// - Raw output keeps working while the system clock is stopped.
// - When disabled, routed outputs read low and comparator power is off.
// - Enable bit 1 turns comparator on, 0 turns it off.
// - Output state bit is readable anytime with no effect on flags.
// - High-to-low output transition sets the falling-edge flag.
// - Low-to-high output transition sets the rising-edge flag.
// - Edge flags stay set; only a software write of 0 or a reset clears them.
// - Edge flags drive rising and falling interrupt requests.
// - Low four control bits select negative and positive hysteresis.
// - Software response-time setting is passed to the analog core.
// - Comparator output is offered to the reset logic as a source.
// - Control: enable bit 7, state bit 6, rise bit 5, fall bit 4.
// - Hysteresis codes 00 off, 01 5mV, 10 10mV, 11 20mV.
// - Two-bit response mode field, mode 0 to 3, resets to 10.
`default_nettype none

module cmc_comparator_ctrl
    import cmc_pkg::*;
(
    input wire logic mclk_i,                          // System clock, 25 MHz
    input wire logic reset_i,                         // Synchronous reset, active high
    input wire logic [cmc_pkg::ADDR_W-1:0] addr_i,    // Register address
    input wire logic [cmc_pkg::DATA_W-1:0] wdata_i,   // Write data
    input wire logic wr_i,                            // Write strobe
    input wire logic rd_i,                            // Read strobe
    output logic [cmc_pkg::DATA_W-1:0] rdata_o,       // Read data, cycle after strobe
    input wire logic cmp_raw_i,                       // Comparator decision from core
    output cmc_pkg::cmc_core_ctrl_s core_ctrl_o,      // Power, hysteresis and mode to core
    output logic raw_cmp_output_o,                    // Unclocked output for port routing
    output logic latched_cmp_output_o,                // Clock-registered output for port
    output logic reset_src_o,                         // Comparator level for reset logic
    output logic rise_irq_o,                          // Rising-edge interrupt request
    output logic fall_irq_o                           // Falling-edge interrupt request
);
    import cmc_pkg::*;

    // Register state
    logic cmp_enable_bit;
    logic next_cmp_enable_bit;
    logic cmp_rise_flag;
    logic next_cmp_rise_flag;
    logic cmp_fall_flag;
    logic next_cmp_fall_flag;
    cmc_hyst_e hyst_positive_sel;
    cmc_hyst_e next_hyst_positive_sel;
    cmc_hyst_e hyst_negative_sel;
    cmc_hyst_e next_hyst_negative_sel;
    cmc_mode_e response_mode_sel;
    cmc_mode_e next_response_mode_sel;

    // Output path state
    logic cmp_sync;
    logic latched_cmp_output;
    logic next_latched_cmp_output;
    logic enable_seen;
    logic next_enable_seen;
    logic edge_rise;
    logic edge_fall;

    // Read path state
    logic [DATA_W-1:0] read_data;
    logic [DATA_W-1:0] next_read_data;

    // Decoded strobes
    logic ctrl_wr;
    logic mode_wr;

    function automatic logic [DATA_W-1:0] ctrl_image(
        input logic en,
        input logic state,
        input logic rise,
        input logic fall,
        input cmc_hyst_e hyp,
        input cmc_hyst_e hyn
    );
        logic [DATA_W-1:0] img;
        img = '0;
        img[CTRL_EN_BIT] = en;
        img[CTRL_OUT_BIT] = state;
        img[CTRL_RISE_BIT] = rise;
        img[CTRL_FALL_BIT] = fall;
        img[CTRL_HYP_LSB +: HYST_W] = hyp;
        img[CTRL_HYN_LSB +: HYST_W] = hyn;
        return img;
    endfunction

    function automatic logic [DATA_W-1:0] mode_image(input cmc_mode_e md);
        logic [DATA_W-1:0] img;
        img = '0;
        img[MODE_SEL_LSB +: MODE_W] = md;
        return img;
    endfunction

    // Address decode
    always_comb begin
        ctrl_wr = wr_i && (addr_i == CTRL_ADDR);
        mode_wr = wr_i && (addr_i == MODE_ADDR);
    end

    // Latched output path
    cmc_sync #(
        .STAGES(SYNC_STAGES)
    ) u_sync (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .async_i(cmp_raw_i),
        .sync_o(cmp_sync)
    );

    always_comb begin
        // Held low while disabled so a routed pin never floats high
        next_latched_cmp_output = cmp_sync & cmp_enable_bit;
        // Edge detection only trusts cycles where the comparator was
        // already on, so the enable or disable step is not flagged
        next_enable_seen = cmp_enable_bit;
        edge_rise = enable_seen && cmp_enable_bit
            && next_latched_cmp_output && !latched_cmp_output;
        edge_fall = enable_seen && cmp_enable_bit
            && !next_latched_cmp_output && latched_cmp_output;
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            latched_cmp_output <= 1'b0;
            enable_seen <= 1'b0;
        end else begin
            latched_cmp_output <= next_latched_cmp_output;
            enable_seen <= next_enable_seen;
        end
    end

    // Control register
    always_comb begin
        next_cmp_enable_bit = cmp_enable_bit;
        next_hyst_positive_sel = hyst_positive_sel;
        next_hyst_negative_sel = hyst_negative_sel;
        next_cmp_rise_flag = cmp_rise_flag;
        next_cmp_fall_flag = cmp_fall_flag;
        if (ctrl_wr) begin
            next_cmp_enable_bit = wdata_i[CTRL_EN_BIT];
            next_hyst_positive_sel = cmc_hyst_e'(wdata_i[CTRL_HYP_LSB +: HYST_W]);
            next_hyst_negative_sel = cmc_hyst_e'(wdata_i[CTRL_HYN_LSB +: HYST_W]);
            next_cmp_rise_flag = wdata_i[CTRL_RISE_BIT];
            next_cmp_fall_flag = wdata_i[CTRL_FALL_BIT];
        end
        // An edge in the same cycle as a clearing write still counts
        if (edge_rise) begin
            next_cmp_rise_flag = 1'b1;
        end
        if (edge_fall) begin
            next_cmp_fall_flag = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cmp_enable_bit <= CTRL_RESET[CTRL_EN_BIT];
            cmp_rise_flag <= CTRL_RESET[CTRL_RISE_BIT];
            cmp_fall_flag <= CTRL_RESET[CTRL_FALL_BIT];
            hyst_positive_sel <= cmc_hyst_e'(CTRL_RESET[CTRL_HYP_LSB +: HYST_W]);
            hyst_negative_sel <= cmc_hyst_e'(CTRL_RESET[CTRL_HYN_LSB +: HYST_W]);
        end else begin
            cmp_enable_bit <= next_cmp_enable_bit;
            cmp_rise_flag <= next_cmp_rise_flag;
            cmp_fall_flag <= next_cmp_fall_flag;
            hyst_positive_sel <= next_hyst_positive_sel;
            hyst_negative_sel <= next_hyst_negative_sel;
        end
    end

    // Mode register
    always_comb begin
        next_response_mode_sel = response_mode_sel;
        if (mode_wr) begin
            next_response_mode_sel = cmc_mode_e'(wdata_i[MODE_SEL_LSB +: MODE_W]);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            response_mode_sel <= cmc_mode_e'(MODE_RESET[MODE_SEL_LSB +: MODE_W]);
        end else begin
            response_mode_sel <= next_response_mode_sel;
        end
    end

    // Read path: reads have no side effects on any flag
    always_comb begin
        next_read_data = READ_IDLE;
        if (rd_i) begin
            case (addr_i)
                CTRL_ADDR: begin
                    next_read_data = ctrl_image(cmp_enable_bit, latched_cmp_output,
                        cmp_rise_flag, cmp_fall_flag,
                        hyst_positive_sel, hyst_negative_sel);
                end
                MODE_ADDR: begin
                    next_read_data = mode_image(response_mode_sel);
                end
                default: begin
                    next_read_data = READ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            read_data <= READ_IDLE;
        end else begin
            read_data <= next_read_data;
        end
    end

    assign rdata_o = read_data;

    // Core settings and outputs
    always_comb begin
        core_ctrl_o.power = cmp_enable_bit;
        core_ctrl_o.hyst_positive_sel = hyst_positive_sel;
        core_ctrl_o.hyst_negative_sel = hyst_negative_sel;
        core_ctrl_o.response_mode_sel = response_mode_sel;
    end

    // Pure gate with no flop in the way, so it keeps following the core
    // while the clock is stopped; glitches on the core pass through too
    assign raw_cmp_output_o = cmp_raw_i & cmp_enable_bit;
    assign latched_cmp_output_o = latched_cmp_output;
    // Raw level is used so a reset can still be raised without a clock
    assign reset_src_o = cmp_raw_i & cmp_enable_bit;
    assign rise_irq_o = cmp_rise_flag;
    assign fall_irq_o = cmp_fall_flag;

endmodule : cmc_comparator_ctrl

`default_nettype wire

// [cmc_comparator_ctrl_monitor.sv]
`default_nettype none

module cmc_monitor
    import cmc_pkg::*;
(
    input wire logic mclk_i, // Clock
    input wire logic reset_i, // Reset
    input wire logic [cmc_pkg::ADDR_W-1:0] addr_i, // Address
    input wire logic [cmc_pkg::DATA_W-1:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    input wire logic [cmc_pkg::DATA_W-1:0] rdata_o, // Read data
    input wire logic cmp_raw_i, // Core decision
    input wire cmc_pkg::cmc_core_ctrl_s core_ctrl_o, // Core settings
    input wire logic raw_cmp_output_o, // Raw output
    input wire logic latched_cmp_output_o, // Latched output
    input wire logic reset_src_o, // Reset source
    input wire logic rise_irq_o, // Rise request
    input wire logic fall_irq_o // Fall request
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    logic pw, steady, ctl_wr, ctl_rd, mode_rd, lat;
    logic [2:0] pw_hist, img;
    logic [4:0] cfg, wcfg;
    logic [1:0] md;
    assign pw = core_ctrl_o.power;
    assign lat = latched_cmp_output_o;
    // Edges right after enabling may be spurious, so only judge a settled enable
    assign steady = pw && (&pw_hist);
    assign ctl_wr = wr_i && addr_i == CTRL_ADDR;
    assign ctl_rd = rd_i && addr_i == CTRL_ADDR;
    assign mode_rd = rd_i && addr_i == MODE_ADDR;
    assign img = {lat, rise_irq_o, fall_irq_o};
    assign cfg = {pw, core_ctrl_o.hyst_positive_sel, core_ctrl_o.hyst_negative_sel};
    assign wcfg = {wdata_i[7], wdata_i[3:0]};
    assign md = core_ctrl_o.response_mode_sel;
    always_ff @(posedge mclk_i) begin
        pw_hist <= reset_i ? 3'h0 : {pw_hist[1:0], pw};
    end
    AST_RAW_GATE: assert property (raw_cmp_output_o == (cmp_raw_i & pw))
        else $error("raw output not gated by enable");
    AST_RESET_SRC: assert property (reset_src_o == raw_cmp_output_o)
        else $error("reset source differs from raw output");
    AST_LATCH_PATH: assert property (steady |-> lat == $past(cmp_raw_i, 3))
        else $error("latched output not three edges behind raw");
    AST_OFF_LOW: assert property (!pw && !$past(pw) |-> !lat)
        else $error("latched output high while disabled");
    AST_RISE_SET: assert property (steady && $rose(lat) |-> rise_irq_o)
        else $error("rising edge not flagged");
    AST_FALL_SET: assert property (steady && $fell(lat) |-> fall_irq_o)
        else $error("falling edge not flagged");
    AST_RISE_HOLD: assert property (rise_irq_o && !(ctl_wr && !wdata_i[5]) |=> rise_irq_o)
        else $error("rise flag dropped without clear");
    AST_FALL_HOLD: assert property (fall_irq_o && !(ctl_wr && !wdata_i[4]) |=> fall_irq_o)
        else $error("fall flag dropped without clear");
    AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == READ_IDLE)
        else $error("read data outside read cycle");
    AST_CTRL_READ: assert property ($past(ctl_rd) |-> rdata_o[6:4] == $past(img))
        else $error("control status bits misread");
    AST_MODE_READ: assert property ($past(mode_rd) |-> rdata_o == {6'h00, $past(md)})
        else $error("mode register misread");
    AST_CFG_WRITE: assert property (ctl_wr |=> cfg == $past(wcfg))
        else $error("control write not applied");
    COV_RISE: cover property (steady && $rose(lat));
    COV_FALL: cover property (steady && $fell(lat));
    COV_CLEAR: cover property (ctl_wr && !wdata_i[5] && rise_irq_o);
endmodule // cmc_monitor

bind cmc_comparator_ctrl cmc_monitor cmc_monitor_i (.mclk_i, .reset_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .cmp_raw_i, .core_ctrl_o, .raw_cmp_output_o,
    .latched_cmp_output_o, .reset_src_o, .rise_irq_o, .fall_irq_o);

`default_nettype wire

// [cmc_core_model.sv]
`default_nettype none

module cmc_core_model
    import cmc_pkg::*;
(
    input wire logic mclk_i, // System clock
    input wire cmc_pkg::cmc_core_ctrl_s core_ctrl_i, // Settings from control
    input wire logic level_i, // Input sign chosen by the bench
    output logic cmp_raw_o // Decision to control
);
    timeunit 1ns;
    timeprecision 1ns;
    logic junk = 1'b0;
    // An unpowered core gives no trustworthy level, so show a changing one
    always_ff @(posedge mclk_i) begin
        junk <= ~junk;
    end
    assign cmp_raw_o = core_ctrl_i.power ? level_i : junk;
endmodule // cmc_core_model

`default_nettype wire

// [cmc_comparator_ctrl_test.sv]
`default_nettype none

module cmc_comparator_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    import cmc_pkg::*;
    logic mclk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, level = 0, clk_run = 1;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, d;
    logic cmp_raw_i, raw_o, lat_o, rsrc_o, rise_o, fall_o;
    cmc_core_ctrl_s core_ctrl_o;
    int mismatches = 0, checked = 0, i;
    cmc_comparator_ctrl cmc_comparator_ctrl_i (.mclk_i(mclk_i), .reset_i(reset_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .cmp_raw_i(cmp_raw_i), .core_ctrl_o(core_ctrl_o), .raw_cmp_output_o(raw_o),
        .latched_cmp_output_o(lat_o), .reset_src_o(rsrc_o), .rise_irq_o(rise_o),
        .fall_irq_o(fall_o));
    cmc_core_model cmc_core_model_i (.mclk_i(mclk_i), .core_ctrl_i(core_ctrl_o),
        .level_i(level), .cmp_raw_o(cmp_raw_i));
    // Clock may be halted to show the raw path needs none
    initial begin
        forever begin
            #20;
            if (clk_run) mclk_i = ~mclk_i;
        end
    end
    task automatic report_and_stop;
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
        chk(n, d, e);
    endtask
    task automatic outs(input string n, input logic [7:0] e);
        repeat (5) @(posedge mclk_i);
        #1 chk(n, {raw_o, rsrc_o, lat_o, rise_o, fall_o}, e);
    endtask
    initial begin
        #100000;
        mismatches++;
        report_and_stop;
    end
    initial begin
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        rdchk("ctrl_reset", CTRL_ADDR, CTRL_RESET);
        rdchk("mode_reset", MODE_ADDR, MODE_RESET);
        wr(8'h00, 8'hFF);
        rdchk("unmapped", 8'h00, READ_IDLE);
        chk("core_reset", core_ctrl_o, 8'h02);
        for (i = 0; i < 4; i++) begin
            wr(MODE_ADDR, 8'hFC | i[7:0]);
            chk("mode_core", core_ctrl_o.response_mode_sel, i[7:0]);
            rdchk("mode_rd", MODE_ADDR, i[7:0]);
        end
        // Bit 6 is status only, so writing it must not show up
        for (i = 0; i < 16; i++) begin
            wr(CTRL_ADDR, 8'h40 | i[7:0]);
            chk("hyst", {core_ctrl_o.hyst_positive_sel, core_ctrl_o.hyst_negative_sel}, i[7:0]);
            rdchk("ctrl_rd", CTRL_ADDR, i[7:0]);
        end
        wr(CTRL_ADDR, 8'h80);
        chk("power", core_ctrl_o.power, 1'b1);
        repeat (6) @(posedge mclk_i);
        wr(CTRL_ADDR, 8'h80);
        rdchk("enabled", CTRL_ADDR, 8'h80);
        @(posedge mclk_i) level <= 1'b1;
        outs("rise_outs", 8'h1E);
        rdchk("rise_rd", CTRL_ADDR, 8'hE0);
        rdchk("rise_again", CTRL_ADDR, 8'hE0);
        @(posedge mclk_i) level <= 1'b0;
        outs("fall_outs", 8'h03);
        rdchk("both_rd", CTRL_ADDR, 8'hB0);
        wr(CTRL_ADDR, 8'hA0);
        rdchk("clear_fall", CTRL_ADDR, 8'hA0);
        @(posedge mclk_i) level <= 1'b1;
        repeat (5) @(posedge mclk_i);
        wr(CTRL_ADDR, 8'h20);
        outs("off_outs", 8'h02);
        rdchk("off_rd", CTRL_ADDR, 8'h20);
        chk("power_off", core_ctrl_o.power, 1'b0);
        wr(CTRL_ADDR, 8'h80);
        @(posedge mclk_i) clk_run = 1'b0;
        #100 level = 1'b0;
        #10 chk("stop_low", raw_o, 1'b0);
        level = 1'b1;
        #10 chk("stop_high", raw_o, 1'b1);
        clk_run = 1'b1;
        repeat (6) @(posedge mclk_i);
        wr(CTRL_ADDR, 8'h80);
        rdchk("restart", CTRL_ADDR, 8'hC0);
        // A reset in mid-run must drop enable, flags and mode back
        @(posedge mclk_i) reset_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        rdchk("ctrl_rerst", CTRL_ADDR, CTRL_RESET);
        rdchk("mode_rerst", MODE_ADDR, MODE_RESET);
        chk("core_rerst", core_ctrl_o, 8'h02);
        report_and_stop;
    end
endmodule // cmc_comparator_ctrl_test

`default_nettype wire
